//--- hdl/crs_map.vh
// Register map, field positions and reset values of the clock, reset and sleep-enable block.
// Assumes a byte-offset register port on the controller peripheral bus, 250 MHz sys_clk.
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

// Register offsets on the peripheral bus
`define CRS_OFS_HB_DIV        8'h04
`define CRS_OFS_STAT_CTRL     8'h08
`define CRS_OFS_HOST_SLEEP    8'h10
`define CRS_OFS_CTRL_SLEEP    8'h14

// Host-bus divisor field
`define CRS_DIV_W             4
`define CRS_DIV_RESET         4'h1
`define CRS_DIV_ZERO          4'h0
`define CRS_DIV_ONE           4'h1

// Status and control bit positions
`define CRS_SC_POWER_GOOD     1
`define CRS_SC_RESET_DRIVE    4
`define CRS_SC_OSC_LOCK       5
`define CRS_SC_DRIVE_RESET    1'b1

// Sleep-enable masks: implemented bits only
`define CRS_HOST_SLEEP_MASK   8'h35
`define CRS_HOST_SLEEP_RESET  8'h00
`define CRS_CTRL_SLEEP_MASK   24'h7F_E1DF
`define CRS_CTRL_SLEEP_RESET  24'h00_0000

// Bus data width and zero fill
`define CRS_DATA_ZERO         32'h0000_0000

// Edge detector settling count after reset
`define CRS_SYNC_SETTLE       3'h5
`define CRS_SETTLE_RESET      3'h0
`define CRS_SETTLE_STEP       3'h1

// Timing: reset assert bound and release bound
`define CRS_CLK_PERIOD_PS     4000
`define CRS_ASSERT_MAX_PS     15000
`define CRS_RELEASE_MAX_PS    46500

`endif

//--- hdl/crs_sync3.v
// Three-stage synchronizer with agreement filter for one asynchronous level.
// Assumes the input is a pin or analog status outside the sys_clk domain.
`timescale 1ns/10ps
module crs_sync3 #(
  parameter RESET_VAL = 1'b0
) (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire async_in,
  output reg  level_ff
);
  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;

  // Stage one feeds stage two only; metastability stays contained
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      level_ff  <= RESET_VAL;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff) begin
        level_ff <= stage3_ff;
      end
    end
  end
endmodule

//--- hdl/crs_top.v
// Clock-enable divider, power-good reset control, oscillator lock and sleep-enable registers.
// Assumes same-clock register strobes from the peripheral bus and an mclk_tick pulse per master clock.
`timescale 1ns/10ps
`include "crs_map.vh"
module crs_top #(
  parameter DIV_W       = `CRS_DIV_W,
  parameter HOST_SLP_W  = 8,
  parameter CTRL_SLP_W  = 24,
  parameter DATA_W      = 32,
  parameter ADDR_W      = 8
) (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  mclk_tick,
  input  wire                  main_power_good_pin,
  input  wire                  crystal_stable,
  input  wire                  ring_osc_in_tolerance,
  input  wire [ADDR_W-1:0]     reg_addr,
  input  wire                  reg_wr_en,
  input  wire                  reg_rd_en,
  input  wire [DATA_W-1:0]     reg_wdata,
  output reg  [DATA_W-1:0]     reg_rdata_ff,
  output reg                   reg_rvalid_ff,
  output reg                   host_bus_clk_en_ff,
  output reg                   internal_system_reset_n_ff,
  output reg                   reset_output_pin_n_ff,
  output reg                   power_good_edge_ff,
  output reg  [HOST_SLP_W-1:0] host_sleep_en_ff,
  output reg  [CTRL_SLP_W-1:0] ctrl_sleep_en_ff
);

  // Synchronized levels
  wire power_good_sync;
  wire crystal_sync;
  wire ring_sync;

  // Register state
  reg  [DIV_W-1:0]      host_bus_clock_divisor_ff;
  reg  [DIV_W-1:0]      nxt_host_bus_clock_divisor;
  reg                   reset_drive_bit_ff;
  reg                   nxt_reset_drive_bit;
  reg  [HOST_SLP_W-1:0] nxt_host_sleep_en;
  reg  [CTRL_SLP_W-1:0] nxt_ctrl_sleep_en;

  // Divider state
  reg  [DIV_W-1:0]      div_count_ff;
  reg  [DIV_W-1:0]      nxt_div_count;
  reg                   nxt_host_bus_clk_en;

  // Power-good edge tracking and oscillator lock
  reg                   power_good_prev_ff;
  reg                   oscillator_lock_ff;

  // Settling count and next reset level
  reg  [2:0]            settle_cnt_ff;
  reg  [2:0]            nxt_settle_cnt;
  reg                   nxt_internal_system_reset_n;

  // Read path
  reg  [DATA_W-1:0]     nxt_reg_rdata;
  reg  [7:0]            status_byte;

  // Decoded writes
  wire wr_div;
  wire wr_stat;
  wire wr_host;
  wire wr_ctrl;

  // Reset clear for the reset outputs: a falling power-good pin acts at once
  wire reset_out_clr_n;

  crs_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_power_good (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (main_power_good_pin),
    .level_ff (power_good_sync)
  );

  crs_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_crystal (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (crystal_stable),
    .level_ff (crystal_sync)
  );

  crs_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_ring (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (ring_osc_in_tolerance),
    .level_ff (ring_sync)
  );

  assign wr_div  = reg_wr_en && (reg_addr == `CRS_OFS_HB_DIV);
  assign wr_stat = reg_wr_en && (reg_addr == `CRS_OFS_STAT_CTRL);
  assign wr_host = reg_wr_en && (reg_addr == `CRS_OFS_HOST_SLEEP);
  assign wr_ctrl = reg_wr_en && (reg_addr == `CRS_OFS_CTRL_SLEEP);

  // Pin is asynchronous here on purpose; a synchronized path would take 20 ns
  assign reset_out_clr_n = rst_n & main_power_good_pin;

  // Host-bus divisor register
  always @* begin
    nxt_host_bus_clock_divisor = host_bus_clock_divisor_ff;
    if (wr_div && (reg_wdata[DIV_W-1:0] != `CRS_DIV_ZERO)) begin
      nxt_host_bus_clock_divisor = reg_wdata[DIV_W-1:0];
    end
    // A zero write falls through with the old value kept
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_bus_clock_divisor_ff <= `CRS_DIV_RESET;
    end else begin
      host_bus_clock_divisor_ff <= nxt_host_bus_clock_divisor;
    end
  end

  // Clock-enable divider over master-clock ticks
  always @* begin
    nxt_div_count       = div_count_ff;
    nxt_host_bus_clk_en = 1'b0;
    if (mclk_tick) begin
      // Compare with >= so a divisor shrunk mid-count wraps at once
      if ((div_count_ff + `CRS_DIV_ONE) >= host_bus_clock_divisor_ff) begin
        nxt_div_count       = `CRS_DIV_ZERO;
        nxt_host_bus_clk_en = 1'b1;
      end else begin
        nxt_div_count = div_count_ff + `CRS_DIV_ONE;
      end
    end
    // Divisor one: every tick passes, the undivided rate
    if (mclk_tick && (host_bus_clock_divisor_ff == `CRS_DIV_ONE)) begin
      nxt_host_bus_clk_en = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count_ff       <= `CRS_DIV_ZERO;
      host_bus_clk_en_ff <= 1'b0;
    end else begin
      div_count_ff       <= nxt_div_count;
      host_bus_clk_en_ff <= nxt_host_bus_clk_en;
    end
  end

  // Reset-drive bit: writes land only with power good
  always @* begin
    nxt_reset_drive_bit = reset_drive_bit_ff;
    if (wr_stat && power_good_sync) begin
      nxt_reset_drive_bit = reg_wdata[`CRS_SC_RESET_DRIVE];
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_drive_bit_ff <= `CRS_SC_DRIVE_RESET;
    end else begin
      reset_drive_bit_ff <= nxt_reset_drive_bit;
    end
  end

  // Low power good wins; otherwise the inverse of the drive bit
  // Release waits for the synchronized level, so a pin glitch cannot free it
  always @* begin
    case (power_good_sync)
      1'b0: begin
        nxt_internal_system_reset_n = 1'b0;
      end
      default: begin
        nxt_internal_system_reset_n = ~reset_drive_bit_ff;
      end
    endcase
  end

  // System reset and its pin share one equation and one clear
  always @(posedge sys_clk or negedge reset_out_clr_n) begin
    if (!reset_out_clr_n) begin
      internal_system_reset_n_ff <= 1'b0;
      reset_output_pin_n_ff      <= 1'b0;
    end else begin
      // Internal reset and the pin both follow the inverse of the bit
      internal_system_reset_n_ff <= nxt_internal_system_reset_n;
      reset_output_pin_n_ff      <= nxt_internal_system_reset_n;
    end
  end

  // Edge detector waits for the synchronizer to fill after reset, or the
  // first real sample of a high pin would look like a rising edge
  always @* begin
    nxt_settle_cnt = settle_cnt_ff;
    if (settle_cnt_ff != `CRS_SYNC_SETTLE) begin
      nxt_settle_cnt = settle_cnt_ff + `CRS_SETTLE_STEP;
    end
  end

  // Saturating count of cycles since reset
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_ff <= `CRS_SETTLE_RESET;
    end else begin
      settle_cnt_ff <= nxt_settle_cnt;
    end
  end

  // Either-edge event for the interrupt aggregator; an edge inside the
  // settling window after reset is not reported
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_good_prev_ff <= 1'b0;
      power_good_edge_ff <= 1'b0;
    end else begin
      power_good_prev_ff <= power_good_sync;
      if (settle_cnt_ff == `CRS_SYNC_SETTLE) begin
        power_good_edge_ff <= power_good_sync ^ power_good_prev_ff;
      end else begin
        power_good_edge_ff <= 1'b0;
      end
    end
  end

  // Lock needs both conditions together
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_lock_ff <= 1'b0;
    end else begin
      oscillator_lock_ff <= crystal_sync & ring_sync;
    end
  end

  // Sleep-enable registers; masks keep reserved bits at zero
  always @* begin
    nxt_host_sleep_en = host_sleep_en_ff;
    nxt_ctrl_sleep_en = ctrl_sleep_en_ff;
    if (wr_host) begin
      nxt_host_sleep_en = reg_wdata[HOST_SLP_W-1:0] & `CRS_HOST_SLEEP_MASK;
    end
    if (wr_ctrl) begin
      nxt_ctrl_sleep_en = reg_wdata[CTRL_SLP_W-1:0] & `CRS_CTRL_SLEEP_MASK;
    end
  end

  // Bus interface, legacy port and mailbox have no enable here at all
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_sleep_en_ff <= `CRS_HOST_SLEEP_RESET;
      ctrl_sleep_en_ff <= `CRS_CTRL_SLEEP_RESET;
    end else begin
      host_sleep_en_ff <= nxt_host_sleep_en;
      ctrl_sleep_en_ff <= nxt_ctrl_sleep_en;
    end
  end

  // Status byte assembly
  always @* begin
    status_byte                      = 8'h00;
    status_byte[`CRS_SC_POWER_GOOD]  = power_good_sync;
    status_byte[`CRS_SC_RESET_DRIVE] = reset_drive_bit_ff;
    status_byte[`CRS_SC_OSC_LOCK]    = oscillator_lock_ff;
  end

  // Read mux; unmapped offsets answer zero
  always @* begin
    nxt_reg_rdata = `CRS_DATA_ZERO;
    case (reg_addr)
      `CRS_OFS_HB_DIV: begin
        nxt_reg_rdata[DIV_W-1:0] = host_bus_clock_divisor_ff;
      end
      `CRS_OFS_STAT_CTRL: begin
        nxt_reg_rdata[7:0] = status_byte;
      end
      `CRS_OFS_HOST_SLEEP: begin
        nxt_reg_rdata[HOST_SLP_W-1:0] = host_sleep_en_ff;
      end
      `CRS_OFS_CTRL_SLEEP: begin
        nxt_reg_rdata[CTRL_SLP_W-1:0] = ctrl_sleep_en_ff;
      end
      default: begin
        nxt_reg_rdata = `CRS_DATA_ZERO;
      end
    endcase
  end

  // Read data holds until the next read
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff  <= `CRS_DATA_ZERO;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_ff <= nxt_reg_rdata;
      end
    end
  end

endmodule

//--- hdl/crs_pad_unused.v
`timescale 1ns/10ps

//--- tb/crs_checker.sv
// Port-level assertions for the clock, reset and sleep-enable block.
// Assumes one sys_clk domain; bound into crs_top below.
`timescale 1ns/10ps
module crs_checker (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        mclk_tick,
  input wire        main_power_good_pin,
  input wire [7:0]  reg_addr,
  input wire        reg_rd_en,
  input wire [31:0] reg_rdata_ff,
  input wire        reg_rvalid_ff,
  input wire        host_bus_clk_en_ff,
  input wire        internal_system_reset_n_ff,
  input wire        reset_output_pin_n_ff,
  input wire        power_good_edge_ff,
  input wire [7:0]  host_sleep_en_ff,
  input wire [23:0] ctrl_sleep_en_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_pin_mirrors_reset: assert property (reset_output_pin_n_ff == internal_system_reset_n_ff)
    else $error("reset pin differs from internal reset");
  a_power_loss_reset: assert property (!main_power_good_pin |-> !internal_system_reset_n_ff)
    else $error("reset released without power good");
  // Release only after the synchronizer has seen power good
  a_release_after_sync: assert property ($rose(internal_system_reset_n_ff) |-> $past(main_power_good_pin, 3))
    else $error("reset released too early");
  a_host_sleep_read: assert property (reg_rd_en && reg_addr == 8'h10 |=> reg_rdata_ff == {24'h00_0000, $past(host_sleep_en_ff)})
    else $error("host sleep read mismatch");
  a_ctrl_sleep_read: assert property (reg_rd_en && reg_addr == 8'h14 |=> reg_rdata_ff == {8'h00, $past(ctrl_sleep_en_ff)})
    else $error("controller sleep read mismatch");
  a_reserved_stay_zero: assert property ((host_sleep_en_ff & 8'hCA) == 8'h00 && (ctrl_sleep_en_ff & 24'h80_1E20) == 24'h00_0000)
    else $error("reserved sleep bit set");
  a_enable_after_tick: assert property (host_bus_clk_en_ff |-> $past(mclk_tick))
    else $error("clock enable without master tick");
  a_edge_one_cycle: assert property (power_good_edge_ff |=> !power_good_edge_ff)
    else $error("power good edge pulse too long");
  a_unmapped_reads_zero: assert property (reg_rd_en && reg_addr == 8'h20 |=> reg_rvalid_ff && reg_rdata_ff == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind crs_top crs_checker u_crs_checker (.sys_clk, .rst_n, .mclk_tick, .main_power_good_pin, .reg_addr, .reg_rd_en,
  .reg_rdata_ff, .reg_rvalid_ff, .host_bus_clk_en_ff, .internal_system_reset_n_ff, .reset_output_pin_n_ff,
  .power_good_edge_ff, .host_sleep_en_ff, .ctrl_sleep_en_ff);

//--- tb/tb_top.sv
// Self-checking bench for the clock, reset and sleep-enable block.
// Drives all inputs at the falling edge; checker bound separately.
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk = 0, rst_n = 0, mclk_tick = 1, main_power_good_pin = 1;
  logic        crystal_stable = 0, ring_osc_in_tolerance = 0, reg_wr_en = 0, reg_rd_en = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_ff;
  logic        reg_rvalid_ff, host_bus_clk_en_ff, internal_system_reset_n_ff, reset_output_pin_n_ff;
  logic        power_good_edge_ff;
  logic [7:0]  host_sleep_en_ff;
  logic [23:0] ctrl_sleep_en_ff;
  int          num_errors = 0, n_tests = 0, n, slow = 0, edges = 0;
  int          divs[3] = '{1, 2, 15};
  crs_top u_crs_top (.sys_clk, .rst_n, .mclk_tick, .main_power_good_pin, .crystal_stable, .ring_osc_in_tolerance,
    .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff, .host_bus_clk_en_ff,
    .internal_system_reset_n_ff, .reset_output_pin_n_ff, .power_good_edge_ff, .host_sleep_en_ff, .ctrl_sleep_en_ff);
  always #2 sys_clk = ~sys_clk;
  // Slow mode gives a master tick every other cycle
  always @(negedge sys_clk) mclk_tick <= slow ? ~mclk_tick : 1'b1;
  always @(posedge sys_clk) if (power_good_edge_ff === 1'b1) edges++;
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1;
    @(negedge sys_clk);
    reg_wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1;
    @(negedge sys_clk);
    reg_rd_en = 0;
    chk(reg_rdata_ff, exp);
  endtask
  // Last pass measures a settled period between enables
  task automatic gap(input int exp);
    repeat (3) begin
      n = 0;
      @(negedge sys_clk);
      while (host_bus_clk_en_ff !== 1'b1 && n < 99) begin
        @(negedge sys_clk);
        n++;
      end
    end
    chk(n + 1, exp);
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    repeat (8) @(negedge sys_clk);
    rd(8'h04, 32'h0000_0001);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h08, 32'h0000_0012);
    chk(internal_system_reset_n_ff, 1'h0);
    chk(edges, 0);
    foreach (divs[i]) begin
      wr(8'h04, divs[i]);
      gap(divs[i]);
    end
    wr(8'h04, 32'h0000_0000);
    rd(8'h04, 32'h0000_000F);
    slow = 1;
    wr(8'h04, 32'h0000_0003);
    gap(6);
    slow = 0;
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0035);
    chk(host_sleep_en_ff, 8'h35);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h007F_E1DF);
    chk(ctrl_sleep_en_ff, 24'h7F_E1DF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    chk(internal_system_reset_n_ff, 1'h1);
    chk(reset_output_pin_n_ff, 1'h1);
    wr(8'h08, 32'h0000_0010);
    repeat (2) @(negedge sys_clk);
    chk(reset_output_pin_n_ff, 1'h0);
    wr(8'h08, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    edges = 0;
    main_power_good_pin = 0;
    #1 chk(internal_system_reset_n_ff, 1'h0);
    repeat (10) @(negedge sys_clk);
    wr(8'h08, 32'h0000_0010);
    rd(8'h08, 32'h0000_0000);
    chk(reset_output_pin_n_ff, 1'h0);
    main_power_good_pin = 1;
    repeat (11) @(negedge sys_clk);
    chk(internal_system_reset_n_ff, 1'h1);
    rd(8'h08, 32'h0000_0002);
    chk(edges, 2);
    crystal_stable = 1;
    repeat (10) @(negedge sys_clk);
    rd(8'h08, 32'h0000_0002);
    ring_osc_in_tolerance = 1;
    repeat (10) @(negedge sys_clk);
    rd(8'h08, 32'h0000_0022);
    tally_and_finish;
  end
  initial begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
endmodule
